// ---- logic/octal_switch_defines.svh ----
`ifndef OCTAL_SWITCH_DEFINES_SVH
`define OCTAL_SWITCH_DEFINES_SVH

// Clock rate of clk_i in MHz (50 ns period)
`define CLK_FREQ_MHZ            20

// Timing figures in microseconds
`define FAULT_QUALIFY_TIME_US   100
`define FAULT_QUALIFY_MAX_US    300
`define STARTUP_WAIT_TIME_US    100
`define RESET_LOW_TIME_US       100
`define TURN_ON_DELAY_US        50
`define TURN_OFF_DELAY_US       100

// Derived cycle counts (least times round up; these are exact at 20 MHz)
`define FAULT_QUALIFY_CYCLES    (`FAULT_QUALIFY_TIME_US * `CLK_FREQ_MHZ)
`define STARTUP_WAIT_CYCLES     (`STARTUP_WAIT_TIME_US * `CLK_FREQ_MHZ)
`define QUAL_CNT_W              13

// Command word field positions
`define CMD_OUT_LSB             0
`define CMD_OUT_MSB             7
`define CMD_OLC_LSB             8
`define CMD_OLC_MSB             15
`define CMD_W                   16
`define BIT_CNT_W               5
`define BITS_PER_FRAME          16

// Outputs five and six within the on/off field
`define OUT_FIVE_BIT            4
`define OUT_SIX_BIT             5

// Positions of the external inputs in the synchroniser vector
`define PIN_SCLK                0
`define PIN_CS_N                1
`define PIN_DIN                 2
`define PIN_EN                  3
`define PIN_DD5                 4
`define PIN_DD6                 5
`define PIN_FAULT_LSB           6
`define PIN_OPEN_LSB            14
`define PIN_W                   22

// Reset values
`define RST_CMD                 16'h0000
`define RST_STATUS              8'h00

`endif

// ---- logic/octal_switch_pkg.sv ----
`include "octal_switch_defines.svh"

package octal_switch_pkg;

    // Power mode of the block, one-hot
    typedef enum logic [2:0] {
        ST_SLEEP   = 3'b001,
        ST_STARTUP = 3'b010,
        ST_ACTIVE  = 3'b100
    } mode_t;

    typedef logic [`CMD_W-1:0] cmd_word_t;
    typedef logic [7:0]        lane_t;
    typedef logic [`PIN_W-1:0] pin_vec_t;

endpackage : octal_switch_pkg

// ---- logic/octal_switch_serial_control.sv ----
`timescale 1ns/1ps
`include "octal_switch_defines.svh"

// Contract
// - Fault bit sets only after the condition persists 100 to 300 us.
// - Outputs start switching on within 50 us, off within 100 us.
// - Serial output driven only while chip-select is low.
// - Command acts only at chip-select rising edge.
// - Serial input sampled on each serial clock falling edge while selected.
// - Next bit goes onto serial output on each serial clock rising edge.
// - Chip-select high: ignore clock and data, serial output released.
// - Command one turns output on, zero off, at chip-select rise.
// - A command is sixteen bits within one chip-select low period.
// - Faulted outputs report one, healthy outputs zero.
// - Off output with detection current disabled reports zero; the code still sets the bit on a qualified fault_raw_i.
// - First eight rising edges give zeros, next eight give driver status.
// - Words move MSB first, shift register first-in first-out.
// - Outputs and fault detection work only while enable is high.
// - Enable low turns outputs and detection current off, enters sleep.
// - Logic resets on the rising edge of enable.
// - Bits 15..8 detection current eight..one, bits 7..0 outputs eight..one.
// - Direct drive inputs OR with command bits of outputs five and six.
// - Shift register passes host data through for daisy chaining.
module octal_switch_serial_control #(
    parameter int QUALIFY_CYCLES = `FAULT_QUALIFY_CYCLES, // Fault persistence count
    parameter int STARTUP_CYCLES = `STARTUP_WAIT_CYCLES   // Wait after enable rise
) (
    input  wire logic                       clk_i,                 // 20 MHz system clock
    input  wire logic                       sys_rst_i,             // Synchronous reset, active high
    input  wire logic                       sclk_i,                // Serial clock from host
    input  wire logic                       cs_n_i,                // Chip select, active low
    input  wire logic                       serial_in_i,           // Serial data from host
    input  wire logic                       enable_i,              // Device enable pin
    input  wire logic                       direct_drive_five_i,   // Direct drive of output five
    input  wire logic                       direct_drive_six_i,    // Direct drive of output six
    input  wire octal_switch_pkg::lane_t    fault_raw_i,           // Short, overcurrent or thermal_limit_fault
    input  wire octal_switch_pkg::lane_t    open_off_raw_i,        // Open load seen while output off
    output logic                            serial_out_o,          // Serial data to host
    output logic                            serial_out_oe_o,       // Serial output drive enable
    output octal_switch_pkg::lane_t         output_on_o,           // Gate command per output
    output octal_switch_pkg::lane_t         open_load_current_o,   // Detection current enable per output
    output octal_switch_pkg::lane_t         fault_status_o,        // Qualified fault status
    output logic                            sleep_o,               // Device in sleep
    output logic                            spi_ready_o            // Serial interface active
);
    import octal_switch_pkg::*;

    localparam logic [`QUAL_CNT_W-1:0] QUAL_TOP = QUALIFY_CYCLES[`QUAL_CNT_W-1:0];
    localparam logic [`QUAL_CNT_W-1:0] START_TOP = STARTUP_CYCLES[`QUAL_CNT_W-1:0];
    localparam logic [`BIT_CNT_W-1:0]  FRAME_BITS = `BIT_CNT_W'(`BITS_PER_FRAME);

    typedef struct packed {
        pin_vec_t                           s1;        // Synchroniser first stage
        pin_vec_t                           s2;        // Second stage
        pin_vec_t                           s3;        // Third stage
        pin_vec_t                           filt;      // Accepted input levels
        mode_t                              mode;      // Power mode
        logic [`QUAL_CNT_W-1:0]             start_cnt; // Startup wait counter
        logic                               in_frame;  // Chip-select low seen while active
        logic [`BIT_CNT_W-1:0]              bit_cnt;   // Falling edges this frame, saturating
        cmd_word_t                          shreg;     // Shared in/out shift register
        cmd_word_t                          cmd;       // Latched command word
        logic [7:0][`QUAL_CNT_W-1:0]        qual_cnt;  // Fault persistence counters
        lane_t                              status;    // Qualified fault bits
        logic                               sdo;       // Serial output bit
        logic                               sdo_oe;    // Serial output enable
        lane_t                              out_on;    // Output gate drive
        lane_t                              olc;       // Detection current drive
        logic                               sleep;     // Sleep indicator
        logic                               ready;     // Interface active
    } state_t;

    state_t   st;
    state_t   next_st;
    pin_vec_t pins;

    // Rising edge of a filtered level between this cycle and the next
    function automatic logic rose(input logic prev, input logic now);
        rose = ~prev & now;
    endfunction : rose

    assign pins = {open_off_raw_i, fault_raw_i, direct_drive_six_i, direct_drive_five_i,
                   enable_i, serial_in_i, cs_n_i, sclk_i};

    // Next-state logic for the whole block
    always_comb begin
        logic  en_lvl;
        logic  en_up;
        logic  cs_fall;
        logic  cs_rise;
        logic  sclk_fall;
        logic  sclk_up;
        logic  cond;
        lane_t fault_in;
        lane_t open_in;
        lane_t drive;
        en_lvl    = 1'b0;
        en_up     = 1'b0;
        cs_fall   = 1'b0;
        cs_rise   = 1'b0;
        sclk_fall = 1'b0;
        sclk_up   = 1'b0;
        cond      = 1'b0;
        fault_in  = 8'h00;
        open_in   = 8'h00;
        drive     = 8'h00;
        next_st   = st;

        // Three-stage synchroniser; a change counts once stages two and three agree
        next_st.s1   = pins;
        next_st.s2   = st.s1;
        next_st.s3   = st.s2;
        next_st.filt = ((st.s2 ~^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.filt);

        en_lvl    = next_st.filt[`PIN_EN];
        en_up     = rose(st.filt[`PIN_EN], next_st.filt[`PIN_EN]);
        cs_fall   = rose(~st.filt[`PIN_CS_N], ~next_st.filt[`PIN_CS_N]);
        cs_rise   = rose(st.filt[`PIN_CS_N], next_st.filt[`PIN_CS_N]);
        sclk_fall = rose(~st.filt[`PIN_SCLK], ~next_st.filt[`PIN_SCLK]);
        sclk_up   = rose(st.filt[`PIN_SCLK], next_st.filt[`PIN_SCLK]);
        fault_in  = next_st.filt[`PIN_FAULT_LSB +: 8];
        open_in   = next_st.filt[`PIN_OPEN_LSB +: 8];

        // Power mode sequencing
        case (st.mode)
            ST_SLEEP: begin
                if (en_up) begin
                    // Power-on reset of the logic on enable rise
                    next_st.mode      = ST_STARTUP;
                    next_st.start_cnt = '0;
                    next_st.cmd       = `RST_CMD;
                    next_st.shreg     = `RST_CMD;
                end
            end
            ST_STARTUP: begin
                if (!en_lvl) begin
                    next_st.mode = ST_SLEEP;
                end else if (st.start_cnt == START_TOP - 1'b1) begin
                    // Serial interface stays deaf until the wait has passed
                    next_st.mode = ST_ACTIVE;
                end else begin
                    next_st.start_cnt = st.start_cnt + 1'b1;
                end
            end
            ST_ACTIVE: begin
                if (!en_lvl) begin
                    next_st.mode = ST_SLEEP;
                end
            end
            default: begin
                next_st.mode = ST_SLEEP;
            end
        endcase

        // Serial frame handling; a frame only starts with a clean chip-select fall
        if (st.mode != ST_ACTIVE || !en_lvl) begin
            next_st.in_frame = 1'b0;
            next_st.sdo_oe   = 1'b0;
            next_st.sdo      = 1'b0;
        end else if (cs_fall) begin
            next_st.in_frame = 1'b1;
            next_st.bit_cnt  = '0;
            next_st.shreg    = {8'h00, st.status};
            next_st.sdo      = 1'b0;
            next_st.sdo_oe   = 1'b1;
        end else if (cs_rise) begin
            next_st.in_frame = 1'b0;
            next_st.sdo_oe   = 1'b0;
            // Short frames are dropped so a glitch cannot reprogram the outputs
            if (st.in_frame && st.bit_cnt >= FRAME_BITS) begin
                next_st.cmd = st.shreg;
            end
        end else if (st.in_frame && !next_st.filt[`PIN_CS_N]) begin
            if (sclk_fall) begin
                // Bits beyond sixteen push older data out toward the next device
                next_st.shreg = {st.shreg[`CMD_W-2:0], next_st.filt[`PIN_DIN]};
                if (st.bit_cnt != FRAME_BITS) begin
                    next_st.bit_cnt = st.bit_cnt + 1'b1;
                end
            end
            if (sclk_up) begin
                next_st.sdo = st.shreg[`CMD_W-1];
            end
        end

        // Output and detection current drive, forced off while disabled
        if (en_lvl && st.mode != ST_SLEEP) begin
            drive                = st.cmd[`CMD_OUT_MSB:`CMD_OUT_LSB];
            drive[`OUT_FIVE_BIT] = drive[`OUT_FIVE_BIT] | next_st.filt[`PIN_DD5];
            drive[`OUT_SIX_BIT]  = drive[`OUT_SIX_BIT] | next_st.filt[`PIN_DD6];
            next_st.out_on       = drive;
            next_st.olc          = st.cmd[`CMD_OLC_MSB:`CMD_OLC_LSB];
        end else begin
            next_st.out_on = 8'h00;
            next_st.olc    = 8'h00;
        end

        // Fault qualification; open-off faults count only with detection current on
        for (int i = 0; i < 8; i++) begin
            cond = en_lvl && (st.mode != ST_SLEEP) &&
                   (fault_in[i] || (!st.out_on[i] && st.olc[i] && open_in[i]));
            if (!cond) begin
                next_st.qual_cnt[i] = '0;
                next_st.status[i]   = 1'b0;
            end else if (st.qual_cnt[i] != QUAL_TOP) begin
                next_st.qual_cnt[i] = st.qual_cnt[i] + 1'b1;
                next_st.status[i]   = (st.qual_cnt[i] == QUAL_TOP - 1'b1);
            end else begin
                next_st.status[i] = 1'b1;
            end
        end

        next_st.sleep = (next_st.mode == ST_SLEEP);
        next_st.ready = (next_st.mode == ST_ACTIVE);
    end

    // State register; reset clears the state except mode, which loads ST_SLEEP, and sleep, which is set
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st        <= '0;
            st.mode   <= ST_SLEEP;
            st.cmd    <= `RST_CMD;
            st.status <= `RST_STATUS;
            st.sleep  <= 1'b1;
            st.filt   <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Ports straight from state flops
    assign serial_out_o        = st.sdo;
    assign serial_out_oe_o     = st.sdo_oe;
    assign output_on_o         = st.out_on;
    assign open_load_current_o = st.olc;
    assign fault_status_o      = st.status;
    assign sleep_o             = st.sleep;
    assign spi_ready_o         = st.ready;

endmodule : octal_switch_serial_control

// ---- verification/octal_switch_serial_control_asserts.sv ----
`timescale 1ns/1ps
module octal_switch_serial_control_asserts #(
    parameter int QUALIFY_CYCLES = 2000, // Fault persistence count
    parameter int STARTUP_CYCLES = 2000  // Wait after enable rise
) (
    input wire logic                    clk_i,               // System clock
    input wire logic                    sys_rst_i,           // Sync reset
    input wire logic                    sclk_i,              // Serial clock
    input wire logic                    cs_n_i,              // Chip select
    input wire logic                    serial_in_i,         // Serial data in
    input wire logic                    enable_i,            // Enable pin
    input wire logic                    direct_drive_five_i, // Direct drive five
    input wire logic                    direct_drive_six_i,  // Direct drive six
    input wire octal_switch_pkg::lane_t fault_raw_i,         // Raw faults
    input wire octal_switch_pkg::lane_t open_off_raw_i,      // Raw open loads
    input wire logic                    serial_out_o,        // Serial data out
    input wire logic                    serial_out_oe_o,     // Serial drive enable
    input wire octal_switch_pkg::lane_t output_on_o,         // Gate commands
    input wire octal_switch_pkg::lane_t open_load_current_o, // Detection currents
    input wire octal_switch_pkg::lane_t fault_status_o,      // Qualified faults
    input wire logic                    sleep_o,             // Sleep flag
    input wire logic                    spi_ready_o          // Interface active
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic [15:0] raw_run;
    logic [15:0] cs_high_run;
    // Saturating run lengths; the pin-side count bounds the filtered one from above
    always_ff @(posedge clk_i) begin
        if (sys_rst_i || !(fault_raw_i[0] || open_off_raw_i[0])) raw_run <= 16'h0000;
        else if (raw_run != 16'hFFFF) raw_run <= raw_run + 16'h0001;
        if (sys_rst_i || !cs_n_i) cs_high_run <= 16'h0000;
        else if (cs_high_run != 16'hFFFF) cs_high_run <= cs_high_run + 16'h0001;
    end
    sequence selected_s;
        spi_ready_o && cs_n_i ##1 (!cs_n_i && enable_i)[*6];
    endsequence
    sequence awake_change_s;
        enable_i[*8] ##0 (open_load_current_o != $past(open_load_current_o));
    endsequence
    chk_oe_select: assert property (selected_s |-> serial_out_oe_o)
        else $error("serial output not driven while selected");
    chk_oe_released: assert property (cs_n_i[*6] |-> !serial_out_oe_o)
        else $error("serial output driven while deselected");
    chk_cmd_at_cs: assert property (awake_change_s |-> cs_high_run inside {[2:12]})
        else $error("command applied away from chip-select rise");
    chk_fault_qualify: assert property ($rose(fault_status_o[0]) |-> raw_run >= QUALIFY_CYCLES)
        else $error("fault bit set before qualification");
    chk_fault_drop: assert property ((!(fault_raw_i[0] || open_off_raw_i[0]))[*6] |-> !fault_status_o[0])
        else $error("fault bit held without condition");
    chk_sleep_quiet: assert property (sleep_o[*2] |->
        (output_on_o | open_load_current_o | fault_status_o) == 8'h00 && !spi_ready_o)
        else $error("outputs active in sleep");
    chk_enable_sleep: assert property ((!enable_i)[*5] |-> sleep_o)
        else $error("no sleep with enable low");
    chk_drive_five: assert property ((enable_i && direct_drive_five_i && !sleep_o)[*5] |-> output_on_o[4])
        else $error("direct drive five ignored");
endmodule : octal_switch_serial_control_asserts

// ---- verification/octal_switch_host_model.sv ----
`timescale 1ns/1ps
module octal_switch_host_model (
    input  wire logic clk_i,           // Pacing clock
    output logic      sclk_o,          // Serial clock, idle low
    output logic      cs_n_o,          // Chip select
    output logic      serial_in_o,     // Data to device
    input  wire logic serial_out_i,    // Data from device
    input  wire logic serial_out_oe_i  // Device drive enable
);
    // Idle bus: clock low, deselected
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        serial_in_o = 1'b0;
    end
    // One frame, MSB first; sel low toggles the clock with chip-select left high
    task automatic xfer(input logic [15:0] tx, input int nbits, input bit sel, output logic [15:0] rx,
                        output int driven);
        rx = 16'h0000;
        driven = 0;
        @(negedge clk_i);
        cs_n_o = !sel;
        repeat (8) @(negedge clk_i);
        for (int k = 0; k < nbits; k++) begin
            sclk_o = 1'b1;
            serial_in_o = tx[15-k];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b0;
            repeat (4) @(negedge clk_i);
            // A released line reads as the inverse, so a drive dropped too early corrupts the word
            rx = {rx[14:0], (serial_out_oe_i === 1'b1) ? serial_out_i : !serial_out_i};
            if (serial_out_oe_i === 1'b1) driven++;
        end
        cs_n_o = 1'b1;
        serial_in_o = !serial_in_o; // No stale level once released
        repeat (8) @(negedge clk_i);
    endtask : xfer
endmodule : octal_switch_host_model

// ---- verification/octal_switch_serial_control_tb_top.sv ----
`timescale 1ns/1ps
module octal_switch_serial_control_tb_top;
    import octal_switch_pkg::*;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        enable_i = 1'b0;
    logic        dd5 = 1'b0;
    logic        dd6 = 1'b0;
    lane_t       fault_raw = 8'h00;
    lane_t       open_raw = 8'h00;
    logic        sclk, cs_n, din, sdo, sdo_oe, sleep, ready;
    lane_t       on_o, olc_o, status_o;
    logic [15:0] rx;
    int          drv;
    int          mismatches = 0;
    int          tests_run = 0;
    always #25 clk_i = ~clk_i;
    octal_switch_serial_control #(.QUALIFY_CYCLES(8), .STARTUP_CYCLES(8)) uut (.clk_i(clk_i),
        .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_i(din), .enable_i(enable_i),
        .direct_drive_five_i(dd5), .direct_drive_six_i(dd6), .fault_raw_i(fault_raw), .open_off_raw_i(open_raw),
        .serial_out_o(sdo), .serial_out_oe_o(sdo_oe), .output_on_o(on_o), .open_load_current_o(olc_o),
        .fault_status_o(status_o), .sleep_o(sleep), .spi_ready_o(ready));
    octal_switch_host_model host (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .serial_in_o(din),
        .serial_out_i(sdo), .serial_out_oe_i(sdo_oe));
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // Sleep with enable low, then wake; waking also clears the command
    task automatic power_up();
        enable_i = 1'b0;
        repeat (20) @(negedge clk_i);
        check("sleep", 16'h0001, {15'h0, sleep});
        check("sleep outputs", 16'h0000, {on_o, olc_o});
        enable_i = 1'b1;
        for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge clk_i);
        repeat (4) @(negedge clk_i);
        check("ready", 16'h0001, {15'h0, ready});
        check("cmd after wake", 16'h0000, {on_o, olc_o});
    endtask : power_up
    // Back-to-back commands, then a short frame and deselected clocking
    task automatic t_command();
        host.xfer(16'hA55A, 16, 1'b1, rx, drv);
        check("cmd1", 16'hA55A, {olc_o, on_o});
        check("zeros", 16'h0000, rx);
        check("driven bits", 16'h0010, 16'(drv));
        host.xfer(16'h0281, 16, 1'b1, rx, drv);
        check("cmd2", 16'h0281, {olc_o, on_o});
        host.xfer(16'hFFFF, 8, 1'b1, rx, drv);
        check("short frame", 16'h0281, {olc_o, on_o});
        host.xfer(16'hFFFF, 16, 1'b0, rx, drv);
        check("deselected", 16'h0281, {olc_o, on_o});
        check("released", 16'h0000, 16'(drv));
    endtask : t_command
    // Short pulse rejected while it lasts; held faults qualify and are read back
    task automatic t_fault();
        fault_raw = 8'h01;
        repeat (5) @(negedge clk_i);
        check("pulse", 16'h0000, {8'h00, status_o});
        fault_raw = 8'h00;
        repeat (20) @(negedge clk_i);
        check("pulse gone", 16'h0000, {8'h00, status_o});
        fault_raw = 8'h41;
        open_raw = 8'h07;
        repeat (40) @(negedge clk_i);
        check("status", 16'h0043, {8'h00, status_o});
        host.xfer(16'h0281, 16, 1'b1, rx, drv);
        check("status word", 16'h0043, rx);
        fault_raw = 8'h00;
        open_raw = 8'h00;
        repeat (10) @(negedge clk_i);
        check("status clear", 16'h0000, {8'h00, status_o});
    endtask : t_fault
    // Direct drives add to the serial command
    task automatic t_direct();
        dd5 = 1'b1;
        repeat (10) @(negedge clk_i);
        check("drive five", 16'h0091, {8'h00, on_o});
        dd6 = 1'b1;
        repeat (10) @(negedge clk_i);
        check("drive six", 16'h00B1, {8'h00, on_o});
        dd5 = 1'b0;
        dd6 = 1'b0;
        repeat (10) @(negedge clk_i);
        check("drives off", 16'h0081, {8'h00, on_o});
    endtask : t_direct
    initial begin
        repeat (8) @(negedge clk_i);
        sys_rst_i = 1'b0;
        power_up();
        t_command();
        t_fault();
        t_direct();
        power_up();
        test_done();
    end
    // Watchdog well past the expected run of about 850 cycles
    initial begin
        #400000;
        mismatches++;
        test_done();
    end
endmodule : octal_switch_serial_control_tb_top
bind octal_switch_serial_control octal_switch_serial_control_asserts #(.QUALIFY_CYCLES(QUALIFY_CYCLES),
    .STARTUP_CYCLES(STARTUP_CYCLES)) chk (.clk_i, .sys_rst_i, .sclk_i, .cs_n_i, .serial_in_i, .enable_i,
    .direct_drive_five_i, .direct_drive_six_i, .fault_raw_i, .open_off_raw_i, .serial_out_o, .serial_out_oe_o,
    .output_on_o, .open_load_current_o, .fault_status_o, .sleep_o, .spi_ready_o);
